// file: bios_attr_pkg.sv
// constants for the legacy BIOS segment attribute maps
package bios_attr_pkg;

    // ==================================================================
    // configuration offsets and reset values
    localparam logic [7:0]  TOP_ATTR_OFFSET = 8'h90;
    localparam logic [7:0]  LOW_ATTR_OFFSET = 8'h91;
    localparam logic [7:0]  ATTR_RESET      = 8'h00;

    // ==================================================================
    // field layout inside each map byte
    localparam int          UPPER_FIELD_LSB = 4;
    localparam int          LOWER_FIELD_LSB = 0;
    localparam logic [7:0]  TOP_WRITE_MASK  = 8'h30;
    localparam logic [7:0]  LOW_WRITE_MASK  = 8'h33;
    localparam int          READ_CLAIM_BIT  = 0;
    localparam int          WRITE_CLAIM_BIT = 1;
    localparam logic [1:0]  ATTR_BOTH_MEM   = 2'h3;

    // ==================================================================
    // legacy address window and segment bases
    localparam int          ADDR_W          = 20;
    localparam logic [19:0] LEGACY_LO       = 20'hC0000;
    localparam logic [19:0] TOP_SEG_BASE    = 20'hF0000;
    localparam logic [19:0] C4_SEG_BASE     = 20'hC4000;
    localparam logic [19:0] C0_SEG_BASE     = 20'hC0000;
    localparam int          TOP_SEG_SHIFT   = 16;
    localparam int          SMALL_SEG_SHIFT = 14;
    localparam int          SEG_COUNT       = 3;

endpackage : bios_attr_pkg

// file: cycle_source.sv
// behavioural processor and initiator source of memory cycles
`timescale 1ns/1ps
module cycle_source
    import bios_attr_pkg::*;
(
    input  wire logic              go,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic              cmd_write,
    input  wire logic              cmd_init,
    output logic                   req_valid,
    output logic      [ADDR_W-1:0] req_addr,
    output logic                   req_write,
    output logic                   req_initiator
);
    // ==========================================================
    // request lines
    // idle lines show the inverse of the current command inputs so stale values never match
    always @* begin
        req_valid = go;
        if (go) begin
            req_addr      = cmd_addr;
            req_write     = cmd_write;
            req_initiator = cmd_init;
        end else begin
            req_addr      = ~cmd_addr;
            req_write     = ~cmd_write;
            req_initiator = ~cmd_init;
        end
    end
endmodule : cycle_source

// file: legacy_bios_area_attribute_map.sv
// legacy BIOS segment attribute maps: config registers and cycle steering
`timescale 1ns/1ps

// What this block does
// - The first map is an 8-bit config register at offset 90h, reset to 00h.
// - Three legacy segments between 768 KB and 1 MB get programmable routing attributes.
// - A set read bit sends reads to main memory, a clear one sends them downstream.
// - A set write bit sends writes to main memory, a clear one sends them downstream.
// - The attributes steer processor cycles and bus-initiator cycles alike.
// - Field decode: 00 all downstream, 01 reads to memory, 10 writes to memory, 11 both.
// - Bits 5:4 of the first map cover 0F0000h-0FFFFFh; its other bits read zero.
// - The second map is an 8-bit register at 91h, reset 00h, bits 7:6 and 3:2 zero.
// - Bits 5:4 of the second map cover 0C4000h-0C7FFFh.
// - Bits 1:0 of the second map cover 0C0000h-0C3FFFh.
// - Fields take writes only while the trusted lock is inactive.
// - The second map holds two 2-bit fields, one per region; the first map holds one.
module legacy_bios_area_attribute_map
    import bios_attr_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [7:0]        cfg_wdata,
    output logic      [7:0]        cfg_rdata,
    input  wire logic              trusted_lock_mode,
    input  wire logic              req_valid,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_write,
    input  wire logic              req_initiator,
    output logic                   rsp_valid,
    output logic                   rsp_claimed,
    output logic                   rsp_to_memory,
    output logic                   rsp_to_downstream,
    output logic                   initiator_hazard
);

    // ==================================================================
    // state
    logic [7:0] top_bios_segment_attr_ff;
    logic [7:0] expansion_rom_low_attr_ff;
    logic [7:0] rdata_ff;
    logic       valid_ff;
    logic       claimed_ff;
    logic       mem_ff;
    logic       down_ff;
    logic       hazard_ff;
    logic [7:0] nxt_top_bios_segment_attr;
    logic [7:0] nxt_expansion_rom_low_attr;
    logic [7:0] nxt_rdata;
    logic       nxt_valid;
    logic       nxt_claimed;
    logic       nxt_mem;
    logic       nxt_down;
    logic       nxt_hazard;
    logic       any_hit;
    logic       any_mem;
    logic [1:0] hit_attr;

    seg_route_if seg_bus [SEG_COUNT] ();

    // ==================================================================
    // segment decoders: top 64 KB, 0C4000h and 0C0000h
    seg_decode #(.SEG_BASE(TOP_SEG_BASE), .SEG_SHIFT(TOP_SEG_SHIFT)) u_top_seg (
        .seg (seg_bus[0])
    );
    seg_decode #(.SEG_BASE(C4_SEG_BASE), .SEG_SHIFT(SMALL_SEG_SHIFT)) u_c4_seg (
        .seg (seg_bus[1])
    );
    seg_decode #(.SEG_BASE(C0_SEG_BASE), .SEG_SHIFT(SMALL_SEG_SHIFT)) u_c0_seg (
        .seg (seg_bus[2])
    );

    // every decoder sees the same cycle; only its own field differs
    for (genvar g = 0; g < SEG_COUNT; g++) begin : g_feed
        assign seg_bus[g].addr     = req_addr;
        assign seg_bus[g].is_write = req_write;
    end
    assign seg_bus[0].attr = top_bios_segment_attr_ff[UPPER_FIELD_LSB +: 2];
    assign seg_bus[1].attr = expansion_rom_low_attr_ff[UPPER_FIELD_LSB +: 2];
    assign seg_bus[2].attr = expansion_rom_low_attr_ff[LOWER_FIELD_LSB +: 2];

    // ==================================================================
    // segments never overlap, so an or-merge picks the single hit
    always_comb begin
        any_hit  = 1'b0;
        any_mem  = 1'b0;
        hit_attr = 2'h0;
        if (seg_bus[0].hit) begin
            any_hit  = 1'b1;
            any_mem  = seg_bus[0].to_mem;
            hit_attr = seg_bus[0].attr;
        end
        if (seg_bus[1].hit) begin
            any_hit  = 1'b1;
            any_mem  = seg_bus[1].to_mem;
            hit_attr = seg_bus[1].attr;
        end
        if (seg_bus[2].hit) begin
            any_hit  = 1'b1;
            any_mem  = seg_bus[2].to_mem;
            hit_attr = seg_bus[2].attr;
        end
    end

    // ==================================================================
    // next values: config writes, config reads, steering answer
    always_comb begin
        nxt_top_bios_segment_attr  = top_bios_segment_attr_ff;
        nxt_expansion_rom_low_attr = expansion_rom_low_attr_ff;
        nxt_rdata                  = rdata_ff;
        // lock freezes both maps; reserved bits are masked off on entry
        if (cfg_wr && !trusted_lock_mode) begin
            if (cfg_addr == TOP_ATTR_OFFSET) begin
                nxt_top_bios_segment_attr = cfg_wdata & TOP_WRITE_MASK;
            end
            if (cfg_addr == LOW_ATTR_OFFSET) begin
                nxt_expansion_rom_low_attr = cfg_wdata & LOW_WRITE_MASK;
            end
        end
        // unmapped offsets read zero; read sees the value before a same-cycle write
        if (cfg_rd) begin
            case (cfg_addr)
                TOP_ATTR_OFFSET: nxt_rdata = top_bios_segment_attr_ff;
                LOW_ATTR_OFFSET: nxt_rdata = expansion_rom_low_attr_ff;
                default:         nxt_rdata = 8'h00;
            endcase
        end
        // initiator and processor cycles share one decode path
        nxt_valid   = req_valid;
        nxt_claimed = req_valid && any_hit;
        nxt_mem     = req_valid && any_hit && any_mem;
        nxt_down    = req_valid && any_hit && !any_mem;
        // flags a cycle that may hang the hub: not a fix, just visibility
        nxt_hazard  = req_valid && any_hit && req_initiator
                      && (hit_attr != ATTR_BOTH_MEM);
    end

    // ==================================================================
    // registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            top_bios_segment_attr_ff  <= ATTR_RESET;
            expansion_rom_low_attr_ff <= ATTR_RESET;
            rdata_ff                  <= 8'h00;
            valid_ff                  <= 1'b0;
            claimed_ff                <= 1'b0;
            mem_ff                    <= 1'b0;
            down_ff                   <= 1'b0;
            hazard_ff                 <= 1'b0;
        end else begin
            top_bios_segment_attr_ff  <= nxt_top_bios_segment_attr;
            expansion_rom_low_attr_ff <= nxt_expansion_rom_low_attr;
            rdata_ff                  <= nxt_rdata;
            valid_ff                  <= nxt_valid;
            claimed_ff                <= nxt_claimed;
            mem_ff                    <= nxt_mem;
            down_ff                   <= nxt_down;
            hazard_ff                 <= nxt_hazard;
        end
    end

    assign cfg_rdata         = rdata_ff;
    assign rsp_valid         = valid_ff;
    assign rsp_claimed       = claimed_ff;
    assign rsp_to_memory     = mem_ff;
    assign rsp_to_downstream = down_ff;
    assign initiator_hazard  = hazard_ff;

    // ==================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    lock_blocks_write_a: assert property (
        cfg_wr && trusted_lock_mode |=> $stable(top_bios_segment_attr_ff)
                                        && $stable(expansion_rom_low_attr_ff))
        else $error("map changed while locked");

    top_write_take_a: assert property (
        cfg_wr && !trusted_lock_mode && cfg_addr == TOP_ATTR_OFFSET
        |=> top_bios_segment_attr_ff == ($past(cfg_wdata) & 8'h30))
        else $error("top map write not stored");

    reserved_zero_a: assert property (
        (top_bios_segment_attr_ff & 8'hCF) == 8'h00
        && (expansion_rom_low_attr_ff & 8'hCC) == 8'h00)
        else $error("reserved map bit set");

    map_readback_a: assert property (
        cfg_rd && cfg_addr == LOW_ATTR_OFFSET
        |=> cfg_rdata == $past(expansion_rom_low_attr_ff))
        else $error("second map readback wrong");

    unmapped_read_a: assert property (
        cfg_rd && cfg_addr != 8'h90 && cfg_addr != 8'h91 |=> cfg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");

    top_read_route_a: assert property (
        req_valid && !req_write && req_addr[19:16] == 4'hF
        |=> rsp_claimed && rsp_to_memory == $past(top_bios_segment_attr_ff[4]))
        else $error("top segment read misrouted");

    c0_write_route_a: assert property (
        req_valid && req_write && req_addr[19:14] == 6'h30
        |=> rsp_to_downstream == !$past(expansion_rom_low_attr_ff[1]))
        else $error("0C0000h write misrouted");

    c4_read_route_a: assert property (
        req_valid && !req_write && req_addr[19:14] == 6'h31
        |=> rsp_to_memory == $past(expansion_rom_low_attr_ff[4]))
        else $error("0C4000h read misrouted");

    route_exclusive_a: assert property (
        rsp_valid |-> !(rsp_to_memory && rsp_to_downstream)
                      && rsp_claimed == (rsp_to_memory || rsp_to_downstream))
        else $error("answer routes both ways");

    answer_timing_a: assert property (
        req_valid ##1 !req_valid |-> rsp_valid ##1 !rsp_valid)
        else $error("answer not one cycle after request");

endmodule : legacy_bios_area_attribute_map

// file: legacy_bios_area_attribute_map_tb.sv
// self-checking bench for the legacy BIOS segment attribute maps
`timescale 1ns/1ps
module legacy_bios_area_attribute_map_tb;
    import bios_attr_pkg::*;
    logic              sys_clk, rst_n, cfg_wr, cfg_rd, trusted_lock_mode;
    logic [7:0]        cfg_addr, cfg_wdata, cfg_rdata, m90, m91, ra;
    logic              req_valid, req_write, req_initiator, go, cmd_write, cmd_init;
    logic [ADDR_W-1:0] req_addr, cmd_addr;
    logic              rsp_valid, rsp_claimed, rsp_to_memory, rsp_to_downstream;
    logic              initiator_hazard;
    logic [19:0]       edges [8];
    logic [31:0]       r;
    int                n_errors, check_count, cycles;

    legacy_bios_area_attribute_map dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .trusted_lock_mode(trusted_lock_mode), .req_valid(req_valid), .req_addr(req_addr),
        .req_write(req_write), .req_initiator(req_initiator), .rsp_valid(rsp_valid),
        .rsp_claimed(rsp_claimed), .rsp_to_memory(rsp_to_memory),
        .rsp_to_downstream(rsp_to_downstream), .initiator_hazard(initiator_hazard));
    cycle_source src (.go(go), .cmd_addr(cmd_addr), .cmd_write(cmd_write),
        .cmd_init(cmd_init), .req_valid(req_valid), .req_addr(req_addr),
        .req_write(req_write), .req_initiator(req_initiator));

    // ==========================================================
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // run needs about 650 cycles, so 8000 means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ==========================================================
    // checking helpers
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    // claimed, memory, downstream, hazard from the shadow maps
    function automatic logic [3:0] route_of(input logic [19:0] a, input logic w, input logic i);
        logic [1:0] f;
        logic       c;
        c = 1'b1;
        if (a[19:16] == 4'hF) f = m90[5:4];
        else if (a[19:14] == 6'h30) f = m91[1:0];
        else if (a[19:14] == 6'h31) f = m91[5:4];
        else begin
            c = 1'b0;
            f = 2'h0;
        end
        return {c, c & f[w], c & ~f[w], c & i & (f != 2'h3)};
    endfunction : route_of
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // bus tasks; inputs move 1 ns after the rising edge
    // a strobe stays up after its edge; the next call drops what it does not use,
    // so no strobe is lowered and raised again in one time step
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        go = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        if (!trusted_lock_mode && a == 8'h90) m90 = d & 8'h30;
        if (!trusted_lock_mode && a == 8'h91) m91 = d & 8'h33;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] a);
        go = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        compare(cfg_rdata, (a == 8'h90) ? m90 : (a == 8'h91) ? m91 : 8'h00);
    endtask : cfg_read
    // leaves the request up so calls run back to back
    task automatic steer(input logic [19:0] a, input logic w, input logic i);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        go = 1'b1;
        cmd_addr = a;
        cmd_write = w;
        cmd_init = i;
        @(posedge sys_clk);
        #1;
        compare({3'h0, rsp_valid, rsp_claimed, rsp_to_memory, rsp_to_downstream,
                 initiator_hazard}, {4'h1, route_of(a, w, i)});
    endtask : steer

    // ==========================================================
    // main sequence
    initial begin
        {rst_n, cfg_wr, cfg_rd, trusted_lock_mode, go, cmd_write, cmd_init} = 7'h00;
        {cfg_addr, cfg_wdata, m90, m91} = 32'h0;
        cmd_addr = 20'h0;
        edges = '{20'hBFFFF, 20'hC0000, 20'hC3FFF, 20'hC4000, 20'hC7FFF, 20'hC8000,
                  20'hF0000, 20'hFFFFF};
        r = $urandom(32'h49F09A85);
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        cfg_read(8'h90);
        cfg_read(8'h91);
        cfg_write(8'h91, 8'hFF);
        cfg_read(8'h91);
        cfg_write(8'h90, 8'hFF);
        cfg_read(8'h90);
        trusted_lock_mode = 1'b1;
        cfg_write(8'h91, 8'h00);
        cfg_read(8'h91);
        trusted_lock_mode = 1'b0;
        // every code in every segment, at both ends of each range
        for (int k = 0; k < 4; k++) begin
            cfg_write(8'h90, {2'h3, k[1:0], 4'hF});
            cfg_write(8'h91, {2'h3, k[1:0], 2'h3, ~k[1:0]});
            for (int e = 0; e < 32; e++) begin
                steer(edges[e % 8], e[3], e[4]);
            end
        end
        go = 1'b0;
        @(posedge sys_clk);
        #1;
        compare({7'h0, rsp_valid}, 8'h00);
        // all segments fully mapped before initiator traffic
        cfg_write(8'h90, 8'h30);
        cfg_write(8'h91, 8'h33);
        steer(20'hC2000, 1'b1, 1'b1);
        // random mix of locked and open writes, reads and cycles
        repeat (500) begin
            r = $urandom;
            trusted_lock_mode = (r[3:0] == 4'h0);
            ra = r[7] ? (8'h90 + {7'h0, r[6]}) : (8'h8E + {5'h0, r[10:8]});
            if (r[5:4] == 2'h0) cfg_write(ra, r[31:24]);
            else if (r[5:4] == 2'h1) cfg_read(ra);
            else steer({r[12] ? 4'hF : {3'b110, r[13]}, r[29:14]}, r[30], r[31]);
        end
        give_verdict();
    end
endmodule : legacy_bios_area_attribute_map_tb

// file: seg_decode.sv
// one legacy segment: address match and memory-or-downstream choice
`timescale 1ns/1ps
module seg_decode
    import bios_attr_pkg::*;
#(
    parameter logic [19:0] SEG_BASE  = 20'hC0000,
    parameter int          SEG_SHIFT = 14
)(
    seg_route_if.decoder seg
);

    // ==================================================================
    // elaboration checks
    if (SEG_SHIFT < 1 || SEG_SHIFT >= ADDR_W) begin : g_bad_shift
        $error("seg_decode: segment size out of range");
    end

    // ==================================================================
    // match upper address bits, then pick the attribute bit for the cycle kind
    always_comb begin
        seg.hit    = (seg.addr >> SEG_SHIFT) == (SEG_BASE >> SEG_SHIFT);
        seg.to_mem = seg.is_write ? seg.attr[WRITE_CLAIM_BIT]
                                  : seg.attr[READ_CLAIM_BIT];
    end

endmodule : seg_decode

// file: seg_route_if.sv
// carrier between the map block and one segment decoder
`timescale 1ns/1ps
interface seg_route_if;
    import bios_attr_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              is_write;
    logic [1:0]        attr;
    logic              hit;
    logic              to_mem;

    modport decoder (input addr, input is_write, input attr, output hit, output to_mem);
    modport owner   (output addr, output is_write, output attr, input hit, input to_mem);
endinterface : seg_route_if
